// ===== design/pfwd_pkg.sv
// Package with timing constants, states and carrier types for the watchdog
package pfwd_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned PWRON_DELAY_MS = 200;
    localparam int unsigned RESET_LOW_MS = 200;
    localparam int unsigned GRACE_S = 120;
    localparam int unsigned BLINK_HZ = 1;
    localparam int unsigned FEED_TIMEOUT_S = 2;
    localparam int unsigned ARM_PULSES = 8;

    localparam int unsigned MS_CYC = CLK_HZ / 1000;
    localparam int unsigned DELAY_CYC = PWRON_DELAY_MS * MS_CYC;
    localparam int unsigned RESET_CYC = RESET_LOW_MS * MS_CYC;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam int unsigned TICK_MS_CYC = MS_CYC;
    localparam int unsigned GRACE_MS = GRACE_S * 1000;
    localparam int unsigned FEED_TIMEOUT_MS = FEED_TIMEOUT_S * 1000;
    localparam int unsigned BLINK_HALF_MS = 1000 / (2 * BLINK_HZ);

    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic RESET_OUT_RST = 1'h1;
    localparam logic IND_RST = 1'h0;
    localparam logic [3:0] PULSE_CNT_RST = 4'h0;

    typedef enum logic [4:0] {
        PFWD_DELAY = 5'h01,
        PFWD_RESET = 5'h02,
        PFWD_GRACE = 5'h04,
        PFWD_ARMING = 5'h08,
        PFWD_FEED = 5'h10
    } pfwd_state_t;

    typedef struct packed {
        logic reset_out_n;
        logic indicator;
        logic armed_feed_mode;
    } pfwd_status_t;

endpackage : pfwd_pkg

// ===== design/pfwd_tick.sv
// Millisecond tick divider producing one-cycle enable pulses
`timescale 1ns/1ps
module pfwd_tick #(
    parameter int unsigned PERIOD = 125_000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Tick output
    output logic tick
);
    logic [31:0] cnt_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_q >= PERIOD - 1) begin
            cnt_q <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : pfwd_tick

// ===== design/pfwd_top.sv
// Pulse-fed system watchdog top level
// Behaviour
// - Four signal terminals: feed input, active-low reset output, indicator drive, armed_feed_mode status output.
// - After power-up wait 200 ms, pulse reset low 200 ms, then release high.
// - After reset pulse, 120 s grace period with indicator toggling at about 1 Hz.
// - After grace, indicator off until the watchdog becomes armed.
// - Eight feed pulses after grace arm feed mode; indicator then lit steadily.
// - 2 s without feed in feed mode restarts delay, reset, grace, arming.
`timescale 1ns/1ps
module pfwd_top #(
    parameter int unsigned DELAY_CYC = pfwd_pkg::DELAY_CYC,
    parameter int unsigned RESET_CYC = pfwd_pkg::RESET_CYC,
    parameter int unsigned TICK_CYC = pfwd_pkg::TICK_MS_CYC,
    parameter int unsigned GRACE_MS = pfwd_pkg::GRACE_MS,
    parameter int unsigned BLINK_HALF_MS = pfwd_pkg::BLINK_HALF_MS,
    parameter int unsigned FEED_TIMEOUT_MS = pfwd_pkg::FEED_TIMEOUT_MS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Host side
    input wire logic feed_in,
    output logic reset_out_n,
    // Indicator and status
    output logic indicator,
    output logic armed_feed_mode
);
    pfwd_pkg::pfwd_state_t state_q;
    logic [31:0] cyc_q;
    logic [31:0] ms_q;
    logic [31:0] blink_q;
    logic [3:0] pulses_q;
    logic [1:0] sync_q;
    logic feed_prev_q;
    logic feed_edge;
    logic ms_tick;
    logic blink_flip;
    pfwd_pkg::pfwd_status_t stat_d;

    // Millisecond enable for long intervals
    pfwd_tick #(
        .PERIOD(TICK_CYC)
    ) u_tick (
        .clk_sys(clk_sys),
        .srst(srst),
        .tick(ms_tick)
    );

    // Feed synchroniser and edge detector
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_q <= pfwd_pkg::SYNC_RST;
            feed_prev_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[0], feed_in};
            feed_prev_q <= sync_q[1];
        end
    end

    assign feed_edge = sync_q[1] & ~feed_prev_q;

    // Sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= pfwd_pkg::PFWD_DELAY;
            cyc_q <= 32'h0;
            ms_q <= 32'h0;
            pulses_q <= pfwd_pkg::PULSE_CNT_RST;
        end else begin
            unique case (state_q)
                pfwd_pkg::PFWD_DELAY: begin
                    if (cyc_q >= DELAY_CYC - 1) begin
                        state_q <= pfwd_pkg::PFWD_RESET;
                        cyc_q <= 32'h0;
                    end else begin
                        cyc_q <= cyc_q + 32'h1;
                    end
                end
                pfwd_pkg::PFWD_RESET: begin
                    if (cyc_q >= RESET_CYC - 1) begin
                        state_q <= pfwd_pkg::PFWD_GRACE;
                        cyc_q <= 32'h0;
                        ms_q <= 32'h0;
                    end else begin
                        cyc_q <= cyc_q + 32'h1;
                    end
                end
                pfwd_pkg::PFWD_GRACE: begin
                    if (ms_tick) begin
                        if (ms_q >= GRACE_MS - 1) begin
                            state_q <= pfwd_pkg::PFWD_ARMING;
                            pulses_q <= pfwd_pkg::PULSE_CNT_RST;
                        end else begin
                            ms_q <= ms_q + 32'h1;
                        end
                    end
                end
                pfwd_pkg::PFWD_ARMING: begin
                    if (feed_edge) begin
                        if (pulses_q == 4'(pfwd_pkg::ARM_PULSES - 1)) begin
                            state_q <= pfwd_pkg::PFWD_FEED;
                            ms_q <= 32'h0;
                        end else begin
                            pulses_q <= pulses_q + 4'h1;
                        end
                    end
                end
                pfwd_pkg::PFWD_FEED: begin
                    if (feed_edge) begin
                        ms_q <= 32'h0;
                    end else if (ms_tick) begin
                        if (ms_q >= FEED_TIMEOUT_MS - 1) begin
                            state_q <= pfwd_pkg::PFWD_DELAY;
                            cyc_q <= 32'h0;
                        end else begin
                            ms_q <= ms_q + 32'h1;
                        end
                    end
                end
                default: begin
                    state_q <= pfwd_pkg::PFWD_DELAY;
                    cyc_q <= 32'h0;
                end
            endcase
        end
    end

    // Blink timer during grace
    always_ff @(posedge clk_sys) begin
        if (srst || state_q != pfwd_pkg::PFWD_GRACE) begin
            blink_q <= 32'h0;
        end else if (ms_tick) begin
            blink_q <= (blink_q >= BLINK_HALF_MS - 1) ? 32'h0 : blink_q + 32'h1;
        end
    end

    // Last grace tick never toggles, so expiry gives no one-cycle flash
    assign blink_flip = ms_tick && blink_q >= BLINK_HALF_MS - 1 && ms_q < GRACE_MS - 1;

    // Output decode
    always_comb begin
        stat_d.reset_out_n = (state_q != pfwd_pkg::PFWD_RESET);
        stat_d.armed_feed_mode = (state_q == pfwd_pkg::PFWD_FEED);
        unique case (state_q)
            pfwd_pkg::PFWD_GRACE: stat_d.indicator = indicator ^ blink_flip;
            pfwd_pkg::PFWD_FEED: stat_d.indicator = 1'b1;
            default: stat_d.indicator = 1'b0;
        endcase
    end

    // Output registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reset_out_n <= pfwd_pkg::RESET_OUT_RST;
            indicator <= pfwd_pkg::IND_RST;
            armed_feed_mode <= 1'b0;
        end else begin
            reset_out_n <= stat_d.reset_out_n;
            indicator <= stat_d.indicator;
            armed_feed_mode <= stat_d.armed_feed_mode;
        end
    end

    // Checks
    sequence s_reset_low;
        !reset_out_n [*8];
    endsequence

    sequence s_enter_reset;
        state_q == pfwd_pkg::PFWD_RESET ##1 !reset_out_n;
    endsequence

    sequence s_leave_reset;
        state_q == pfwd_pkg::PFWD_GRACE ##1 reset_out_n;
    endsequence

    a_reset_pulse_len: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(reset_out_n) |-> s_reset_low) else $error("reset pulse too short");
    a_reset_only_state: assert property (@(posedge clk_sys) disable iff (srst)
        !reset_out_n |-> $past(state_q) == pfwd_pkg::PFWD_RESET) else $error("reset low outside pulse");
    a_feed_light_on: assert property (@(posedge clk_sys) disable iff (srst)
        armed_feed_mode |-> indicator) else $error("indicator not lit when armed");
    a_arming_dark: assert property (@(posedge clk_sys) disable iff (srst)
        $past(state_q) == pfwd_pkg::PFWD_ARMING && state_q == pfwd_pkg::PFWD_ARMING |-> !indicator)
        else $error("indicator lit while waiting to arm");
    a_arm_eighth: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_ARMING && feed_edge && pulses_q == 4'h7 |=> state_q == pfwd_pkg::PFWD_FEED)
        else $error("eighth pulse did not arm");
    a_arm_early: assert property (@(posedge clk_sys) disable iff (srst)
        $past(state_q) == pfwd_pkg::PFWD_ARMING && state_q == pfwd_pkg::PFWD_FEED |-> $past(pulses_q) == 4'h7)
        else $error("armed before eighth pulse");
    a_feed_restart: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_FEED && feed_edge |=> ms_q == 32'h0) else $error("feed did not restart timer");
    a_timeout_seq: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_FEED && !feed_edge && ms_tick && ms_q >= FEED_TIMEOUT_MS - 1
        |=> state_q == pfwd_pkg::PFWD_DELAY && cyc_q == 32'h0) else $error("timeout did not restart");
    a_sync_edge: assert property (@(posedge clk_sys) disable iff (srst)
        feed_edge |-> $past(sync_q[1]) == 1'b0) else $error("edge without rise");
    a_delay_to_reset: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_DELAY && cyc_q >= DELAY_CYC - 1 |=> s_enter_reset)
        else $error("delay did not lead to reset pulse");
    a_reset_release: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_RESET && cyc_q >= RESET_CYC - 1 |=> s_leave_reset)
        else $error("reset pulse not released");
    a_tick_single: assert property (@(posedge clk_sys) disable iff (srst)
        ms_tick |=> !ms_tick)
        else $error("tick longer than one cycle");
    a_blink_on_tick: assert property (@(posedge clk_sys) disable iff (srst)
        $past(state_q) == pfwd_pkg::PFWD_GRACE && !$past(ms_tick) |-> $stable(indicator))
        else $error("indicator changed between ticks");
    a_grace_exit_dark: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_GRACE && ms_tick && ms_q >= GRACE_MS - 1 |=> ##1 !indicator)
        else $error("indicator not off after grace");
    a_arm_fresh: assert property (@(posedge clk_sys) disable iff (srst)
        $past(state_q) == pfwd_pkg::PFWD_GRACE && state_q == pfwd_pkg::PFWD_ARMING |-> pulses_q == pfwd_pkg::PULSE_CNT_RST)
        else $error("arming count not cleared");
    a_arm_count: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_ARMING && feed_edge && pulses_q != 4'(pfwd_pkg::ARM_PULSES - 1)
        |=> state_q == pfwd_pkg::PFWD_ARMING && pulses_q == $past(pulses_q) + 4'h1) else $error("pulse not counted");
    a_feed_steady: assert property (@(posedge clk_sys) disable iff (srst)
        $past(state_q) == pfwd_pkg::PFWD_FEED && state_q == pfwd_pkg::PFWD_FEED |-> indicator && armed_feed_mode)
        else $error("feed mode outputs not steady");
    a_feed_wins: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == pfwd_pkg::PFWD_FEED && feed_edge |=> state_q == pfwd_pkg::PFWD_FEED)
        else $error("feed pulse did not keep feed mode");
    a_state_onehot: assert property (@(posedge clk_sys) disable iff (srst)
        $onehot(state_q))
        else $error("sequencer state not one-hot");

endmodule : pfwd_top

// ===== sim/pfwd_host_model.sv
// Host model that drives feed pulses into the watchdog
`timescale 1ns/1ps
module pfwd_host_model (
    // Clock
    input wire logic clk_sys,
    // Feed output
    output logic feed_in
);
    initial feed_in = 1'h0;
    // One pulse, high and low at least two clocks each
    task pulse(input int hi, input int lo);
        @(negedge clk_sys);
        feed_in = 1'h1;
        repeat (hi) @(negedge clk_sys);
        feed_in = 1'h0;
        repeat (lo - 1) @(negedge clk_sys);
    endtask : pulse
    // Burst of pulses with random widths
    task burst(input int n);
        repeat (n) pulse(2 + $urandom % 3, 2 + $urandom % 3);
    endtask : burst
    // Regular feeding well inside the timeout
    task feed(input int n);
        repeat (n) begin
            pulse(2, 2);
            repeat ($urandom % 9) @(negedge clk_sys);
        end
    endtask : feed
endmodule : pfwd_host_model

// ===== sim/pfwd_top_tb.sv
// Self-checking testbench for the watchdog top level
`timescale 1ns/1ps
module pfwd_top_tb;
    localparam int DLY = 20;
    localparam int RST = 20;
    localparam int TCK = 4;
    localparam int GR = 10;
    localparam int BH = 2;
    localparam int FTO = 5;
    logic clk_sys, srst, feed_in, reset_out_n, indicator, armed_feed_mode, ind_last;
    int n_mismatch, total_checks, cyc, tog, n_fed;

    pfwd_top #(.DELAY_CYC(DLY), .RESET_CYC(RST), .TICK_CYC(TCK), .GRACE_MS(GR), .BLINK_HALF_MS(BH),
        .FEED_TIMEOUT_MS(FTO)) pfwd_top_i (.clk_sys(clk_sys), .srst(srst), .feed_in(feed_in),
        .reset_out_n(reset_out_n), .indicator(indicator), .armed_feed_mode(armed_feed_mode));
    pfwd_host_model pfwd_host_model_i (.clk_sys(clk_sys), .feed_in(feed_in));

    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // Bounded wait until reset (sel 0) or armed (sel 1) reaches a level
    task wait_for(input int sel, input logic val, input int bound, output int n);
        n = 0;
        while (((sel == 0) ? reset_out_n : armed_feed_mode) !== val) begin
            @(negedge clk_sys);
            n++;
            if (n > bound) begin
                n_mismatch++;
                $display("ERROR wait %0d expected %0h seen timeout", sel, val);
                finish_test();
            end
        end
    endtask : wait_for

    initial begin
        srst = 1'h1;
        n_mismatch = 0;
        total_checks = 0;
        void'($urandom(32'h1E08E338));
        repeat (6) @(negedge clk_sys);
        check("reset_out_n", reset_out_n, 1'h1);
        check("indicator", indicator, 1'h0);
        check("armed", armed_feed_mode, 1'h0);
        srst = 1'h0;
        for (int r = 0; r < 2; r++) begin
            n_fed = 0;
            wait_for(0, 1'h0, DLY + 4, cyc);
            check("delay", (cyc >= DLY && cyc <= DLY + 2), 1'h1);
            wait_for(0, 1'h1, RST + 2, cyc);
            check("reset_low", cyc, RST);
            tog = 0;
            ind_last = indicator;
            fork
                pfwd_host_model_i.burst(4);
                repeat (GR * TCK + TCK) begin
                    @(negedge clk_sys);
                    if (indicator !== ind_last) tog++;
                    ind_last = indicator;
                end
            join
            repeat (4) @(negedge clk_sys);
            check("blink", tog, GR / BH - 1);
            check("indicator", indicator, 1'h0);
            check("armed", armed_feed_mode, 1'h0);
            for (int p = 0; p < 8; p++) begin
                pfwd_host_model_i.burst(1);
                n_fed++;
                repeat (2) @(negedge clk_sys);
                check("armed", armed_feed_mode, (n_fed >= 8));
                check("indicator", indicator, (n_fed >= 8));
            end
            pfwd_host_model_i.feed(10);
            check("armed", armed_feed_mode, 1'h1);
            check("reset_out_n", reset_out_n, 1'h1);
            pfwd_host_model_i.pulse(2, 2);
            wait_for(1, 1'h0, FTO * TCK + TCK + 6, cyc);
            check("timeout", (cyc >= (FTO - 1) * TCK + 2 && cyc <= FTO * TCK + 1), 1'h1);
        end
        finish_test();
    end
endmodule : pfwd_top_tb
